// ===== design/midi_port_sync.v
// two-flop synchroniser for a bundle of pin-side levels
`timescale 1ns/10ps
`default_nettype none
module midi_port_sync #(
    parameter WIDTH = 1
) (
    // clock and reset
    input wire clk_in,
    input wire resetn_in,
    // async levels in, synced out
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_r; // first stage, read only by second
    reg [WIDTH-1:0] sync_r; // second stage
    genvar i;
    // one pair of flops per bit
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge clk_in) begin
                if (!resetn_in) begin
                    meta_r[i] <= 1'b0;
                    sync_r[i] <= 1'b0;
                end else begin
                    meta_r[i] <= async_in[i];
                    sync_r[i] <= meta_r[i];
                end
            end
        end
    endgenerate
    assign sync_out = sync_r;
endmodule
`default_nettype wire

// ===== design/midi_stick_map.vh
// port offsets, field positions and reset values of the midi and stick readout block
// Notes on behaviour
// RQ1: 0x206 reads stick B X; writes ignored
// RQ2: 0x207 reads stick B Y; writes ignored
// RQ3: 0x330 reads last rx byte, writes tx
// RQ4: 0x331 rx/tx interrupt enables, pass-through bit 4
// RQ5: serial interrupts drive only interrupt line seven
// RQ6: 0x332 bit 0 shows interrupt pending
// RQ7: 0x335 rx ready, overrun, framing, tx empty
// RQ8: control bit 6 selects automatic stick timing
// RQ9: control bit 0 gates all card interrupts
// RQ10: reserved bits read zero, ignored writes
`ifndef MIDI_STICK_MAP_VH
`define MIDI_STICK_MAP_VH
`define ADDR_CARD_CTRL 10'h202
`define ADDR_STICK_B_X 10'h206
`define ADDR_STICK_B_Y 10'h207
`define ADDR_SER_DATA 10'h330
`define ADDR_SER_IEN 10'h331
`define ADDR_SER_ISTAT 10'h332
`define ADDR_SER_LSTAT 10'h335
`define CTRL_IRQ_MASTER_BIT 0
`define CTRL_AUTO_BIT 6
`define IEN_RX_BIT 0
`define IEN_TX_BIT 1
`define IEN_PASS_BIT 4
`define IEN_MASK 8'h13
`define CTRL_MASK 8'h41
`define LS_RXRDY_BIT 0
`define LS_OVR_BIT 1
`define LS_FRM_BIT 3
`define LS_TXE_BIT 5
`define RST_BYTE 8'h00
`endif

// ===== design/midi_stick_readout.v
// register ports of the midi serial port and second-stick position readout
`timescale 1ns/10ps
`default_nettype none
`include "midi_stick_map.vh"
module midi_stick_readout (
    // clock and reset
    input wire clk_in,
    input wire resetn_in,
    // byte-wide host i/o port, one-cycle strobes
    input wire [9:0] io_addr_in,
    input wire io_rd_in,
    input wire io_wr_in,
    input wire [7:0] io_wdata_in,
    output reg [7:0] io_rdata_out,
    // stick timing hardware, latched axis values
    input wire [7:0] second_stick_x_value_in,
    input wire [7:0] second_stick_y_value_in,
    input wire stick_conv_done_in,
    output wire stick_timing_auto_select_out,
    // serial receiver side
    input wire rx_valid_in,
    input wire [7:0] rx_byte_in,
    input wire rx_frame_err_in,
    // serial transmitter side
    output reg [7:0] tx_byte_out,
    output reg tx_load_out,
    input wire tx_busy_in,
    output wire pass_through_select_out,
    // interrupt line seven
    output wire irq7_out
);
    // host side: one read or write strobe per access, full address compare
    // ports are not aliased, so every unlisted port reads as zero
    // a write to a read-only port changes nothing anywhere
    // read data is registered and holds until the next read strobe
    // serial receiver and transmitter run on this clock, no crossing
    // stick timers run on their own clock; their done level and both
    // axis results pass two flops before any logic looks at them
    // the wide result crossing is safe only because the timers keep it
    // stable while done is high; a timer that changes it early would
    // latch a torn value
    // interrupt output is a pure function of registers, so it never
    // glitches on a strobe and needs no output flop
    // only one serial byte is buffered each way: a slow host loses
    // received bytes and sees overrun
    // conversion done comes from the pulse timers, another domain
    wire conv_done_s;
    wire [15:0] pos_s; // synced X and Y timer results
    reg conv_done_d_r; // edge detect of synced level
    reg [7:0] stick_x_r; // latched stick B X
    reg [7:0] stick_y_r; // latched stick B Y
    reg [7:0] card_ctrl_r; // masked card control bits
    reg [7:0] ien_r; // serial interrupt enables
    reg [7:0] rx_data_r; // last received byte
    reg rx_rdy_r; // received data available
    reg ovr_r; // overrun sticky
    reg frm_r; // framing error sticky
    reg txe_r; // transmit holding empty
    reg tx_pend_r; // byte waiting for transmitter
    wire data_rd; // host read of data port
    wire lstat_rd; // host read of line status
    wire int_pending; // any enabled serial condition
    wire [7:0] lstat; // composed line status

    // done level from the pulse timers, two flops before use
    midi_port_sync #(.WIDTH(1)) u_sync (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .async_in(stick_conv_done_in),
        .sync_out(conv_done_s)
    );

    // axis results cross beside the done level; held stable while done
    // is high, so the latch edge sees settled bytes
    midi_port_sync #(.WIDTH(16)) u_pos_sync (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .async_in({second_stick_x_value_in, second_stick_y_value_in}),
        .sync_out(pos_s)
    );

    // strobe decodes used by the flag clears
    // a write never clears a receive flag; only the matching read does
    assign data_rd = io_rd_in && (io_addr_in == `ADDR_SER_DATA);
    assign lstat_rd = io_rd_in && (io_addr_in == `ADDR_SER_LSTAT);
    assign stick_timing_auto_select_out = card_ctrl_r[`CTRL_AUTO_BIT]; // see RQ8
    assign pass_through_select_out = ien_r[`IEN_PASS_BIT]; // see RQ4
    // pending shows enabled conditions only; the master bit does not
    // hide it from the status port, it only gates the output line
    assign int_pending = (ien_r[`IEN_RX_BIT] && rx_rdy_r) ||
                         (ien_r[`IEN_TX_BIT] && txe_r); // see RQ4
    // master enable gates the only interrupt output
    assign irq7_out = int_pending && card_ctrl_r[`CTRL_IRQ_MASTER_BIT]; // see RQ5 see RQ9
    // line status: bit 5 empty, bit 3 framing, bit 1 overrun, bit 0 ready
    // reserved line status bits are tied to zero
    assign lstat = {2'b00, txe_r, 1'b0, frm_r, 1'b0, ovr_r, rx_rdy_r}; // see RQ7 see RQ10

    // stick positions latch only on a completed automatic conversion
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            conv_done_d_r <= 1'b0;
            // latches read zero until the first automatic conversion
            stick_x_r <= `RST_BYTE;
            stick_y_r <= `RST_BYTE;
        end else begin
            conv_done_d_r <= conv_done_s;
            // manual mode leaves the old result standing
            if (conv_done_s && !conv_done_d_r && card_ctrl_r[`CTRL_AUTO_BIT]) begin // see RQ8
                // synced results pass the same two flops as done, so they line up with the detected edge
                stick_x_r <= pos_s[15:8];
                stick_y_r <= pos_s[7:0];
            end
        end
    end

    // writable control registers; reserved bits masked off
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            // both interrupt enables and the master bit start off
            card_ctrl_r <= `RST_BYTE;
            ien_r <= `RST_BYTE;
        end else if (io_wr_in) begin
            // only the mode and master bits of the control port are kept
            if (io_addr_in == `ADDR_CARD_CTRL) begin
                card_ctrl_r <= io_wdata_in & `CTRL_MASK; // see RQ8 see RQ9 see RQ10
            end else if (io_addr_in == `ADDR_SER_IEN) begin
                ien_r <= io_wdata_in & `IEN_MASK; // see RQ4 see RQ10
            end
            // any other address, read-only ports included, stores nothing
        end
    end

    // receive path: new byte wins over a clearing read in the same cycle
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            rx_data_r <= `RST_BYTE;
            rx_rdy_r <= 1'b0;
            ovr_r <= 1'b0;
            frm_r <= 1'b0;
        end else begin
            if (rx_valid_in) begin
                rx_data_r <= rx_byte_in; // see RQ3
                rx_rdy_r <= 1'b1; // see RQ7
                // unread byte overwritten: overrun, unless read right now
                // the newest byte is kept; the unread one is lost
                if (rx_rdy_r && !data_rd) begin
                    ovr_r <= 1'b1; // see RQ7
                end else if (lstat_rd) begin
                    ovr_r <= 1'b0;
                end
                // framing error belongs to the byte just taken; set beats clear
                if (rx_frame_err_in) begin
                    frm_r <= 1'b1; // see RQ7
                end else if (lstat_rd) begin
                    frm_r <= 1'b0;
                end
            end else begin
                // no new byte: a data read empties the buffer
                if (data_rd) begin
                    rx_rdy_r <= 1'b0;
                end
                // error flags clear when status is read
                if (lstat_rd) begin
                    ovr_r <= 1'b0;
                    frm_r <= 1'b0;
                end
            end
        end
    end

    // transmit holding: one byte, handed over when transmitter idle
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            tx_byte_out <= `RST_BYTE;
            tx_load_out <= 1'b0;
            tx_pend_r <= 1'b0;
            // empty at reset, so an enabled tx interrupt shows pending at once
            txe_r <= 1'b1;
        end else begin
            // load is a one-cycle pulse by default
            tx_load_out <= 1'b0;
            if (io_wr_in && (io_addr_in == `ADDR_SER_DATA)) begin
                tx_byte_out <= io_wdata_in; // see RQ3
                // a write before the hand-over replaces the waiting byte
                tx_pend_r <= 1'b1;
                txe_r <= 1'b0; // see RQ7
            // the gap after a load lets busy rise before the next hand-over
            end else if (tx_pend_r && !tx_busy_in && !tx_load_out) begin
                tx_load_out <= 1'b1;
                tx_pend_r <= 1'b0;
                txe_r <= 1'b1;
            end
        end
    end

    // read mux; unmapped and reserved read zero, writes to RO ports dropped
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            // zero until the first read
            io_rdata_out <= `RST_BYTE;
        end else if (io_rd_in) begin
            // reads have no side effect here; flag clears live with the flags
            if (io_addr_in == `ADDR_STICK_B_X) begin
                io_rdata_out <= stick_x_r; // see RQ1
            end else if (io_addr_in == `ADDR_STICK_B_Y) begin
                io_rdata_out <= stick_y_r; // see RQ2
            end else if (io_addr_in == `ADDR_SER_DATA) begin
                io_rdata_out <= rx_data_r; // see RQ3
            end else if (io_addr_in == `ADDR_SER_IEN) begin
                io_rdata_out <= ien_r; // see RQ4
            end else if (io_addr_in == `ADDR_SER_ISTAT) begin
                io_rdata_out <= {7'h00, int_pending}; // see RQ6 see RQ10
            end else if (io_addr_in == `ADDR_SER_LSTAT) begin
                io_rdata_out <= lstat; // see RQ7
            end else if (io_addr_in == `ADDR_CARD_CTRL) begin
                // only the mode and master enable bits are stored
                io_rdata_out <= card_ctrl_r; // see RQ8 see RQ9
            end else begin
                io_rdata_out <= 8'h00; // see RQ10
            end
        end
    end
endmodule
`default_nettype wire

// ===== test/midi_far_end.sv
// far side: serial source, transmit sink and stick timer
`timescale 1ns/10ps
`default_nettype none
module midi_far_end (
    input wire logic clk_in, tx_load_out,
    input wire logic [7:0] tx_byte_out,
    output logic rx_valid_in, rx_frame_err_in, tx_busy_in, stick_conv_done_in,
    output logic [7:0] rx_byte_in, second_stick_x_value_in, second_stick_y_value_in
);
    int busy_cnt = 0; // line time left for the byte in flight
    int loads = 0; // bytes taken from the block
    logic [7:0] last_tx = 8'h00; // last byte taken
    initial begin
        {rx_valid_in, rx_frame_err_in, stick_conv_done_in} = 3'h0;
        {rx_byte_in, second_stick_x_value_in, second_stick_y_value_in} = 24'h0;
    end
    assign tx_busy_in = busy_cnt != 0;
    // take each load, then stay busy so a second byte must wait
    always @(posedge clk_in) begin
        if (tx_load_out) begin
            loads <= loads + 1;
            last_tx <= tx_byte_out;
        end
        busy_cnt <= tx_load_out ? 8 : (busy_cnt > 0 ? busy_cnt - 1 : 0);
    end
    task send_rx(input logic [7:0] b, input logic fe);
        @(posedge clk_in) #1;
        {rx_byte_in, rx_frame_err_in, rx_valid_in} = {b, fe, 1'b1};
        @(posedge clk_in) #1;
        {rx_byte_in, rx_frame_err_in, rx_valid_in} = {~b, 2'h0}; // stale byte not kept
    endtask
    task stick(input logic [7:0] x, y);
        @(posedge clk_in) #1;
        {second_stick_x_value_in, second_stick_y_value_in, stick_conv_done_in} = {x, y, 1'b1};
        repeat (6) @(posedge clk_in);
        #1 {second_stick_x_value_in, second_stick_y_value_in, stick_conv_done_in} = {~x, ~y, 1'b0};
    endtask
endmodule
`default_nettype wire

// ===== test/midi_port_and_stick_readout_test.sv
// self-checking bench of the midi and stick readout block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module midi_port_and_stick_readout_test;
    logic clk_in = 0, resetn_in = 0, io_rd_in = 0, io_wr_in = 0;
    logic [9:0] io_addr_in = 10'h000;
    logic [7:0] io_wdata_in = 8'h00;
    wire [7:0] io_rdata_out, tx_byte_out, rx_byte_in;
    wire [7:0] second_stick_x_value_in, second_stick_y_value_in;
    wire tx_load_out, tx_busy_in, rx_valid_in, rx_frame_err_in, stick_conv_done_in;
    wire pass_through_select_out, stick_timing_auto_select_out, irq7_out;
    int mismatches = 0, num_checks = 0, cycles = 0;
    always #2 clk_in = ~clk_in;
    midi_stick_readout i_midi_stick_readout (.*);
    midi_far_end i_midi_far_end (.*);
    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // a hang ends the run as a failure
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            stop_test;
        end
    end
    task wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_in) #1;
        {io_addr_in, io_wdata_in, io_wr_in} = {a, d, 1'b1};
        @(posedge clk_in) #1 io_wr_in = 1'b0;
    endtask
    task chk_rd(input logic [9:0] a, input logic [7:0] e);
        @(posedge clk_in) #1;
        {io_addr_in, io_rd_in} = {a, 1'b1};
        @(posedge clk_in) #1 io_rd_in = 1'b0;
        `CHK(io_rdata_out, e)
    endtask
    initial begin
        repeat (20) @(posedge clk_in);
        #1 resetn_in = 1'b1;
        chk_rd(10'h202, 8'h00);
        chk_rd(10'h335, 8'h20);
        chk_rd(10'h000, 8'h00);
        wr(10'h331, 8'hFF);
        chk_rd(10'h331, 8'h13);
        `CHK(pass_through_select_out, 1'b1)
        wr(10'h202, 8'hFF);
        `CHK(irq7_out, 1'b1)
        `CHK(stick_timing_auto_select_out, 1'b1)
        chk_rd(10'h332, 8'h01);
        i_midi_far_end.stick(8'hA5, 8'h3C);
        wr(10'h206, 8'h00);
        wr(10'h207, 8'h00);
        chk_rd(10'h206, 8'hA5);
        chk_rd(10'h207, 8'h3C);
        wr(10'h202, 8'h01);
        `CHK(stick_timing_auto_select_out, 1'b0)
        i_midi_far_end.stick(8'h11, 8'h22);
        chk_rd(10'h206, 8'hA5);
        wr(10'h331, 8'h01);
        `CHK(irq7_out, 1'b0)
        chk_rd(10'h332, 8'h00);
        i_midi_far_end.send_rx(8'h81, 1'b1);
        `CHK(irq7_out, 1'b1)
        wr(10'h335, 8'h00);
        chk_rd(10'h335, 8'h29);
        i_midi_far_end.send_rx(8'h42, 1'b0);
        chk_rd(10'h335, 8'h23);
        wr(10'h202, 8'h00);
        `CHK(irq7_out, 1'b0)
        chk_rd(10'h330, 8'h42);
        chk_rd(10'h335, 8'h20);
        wr(10'h330, 8'h96);
        repeat (3) @(posedge clk_in);
        #1;
        `CHK(i_midi_far_end.last_tx, 8'h96)
        wr(10'h330, 8'h5A);
        repeat (15) @(posedge clk_in);
        #1;
        `CHK(i_midi_far_end.last_tx, 8'h5A)
        `CHK(i_midi_far_end.loads, 2)
        // reset again in mid-run: latches, enables and status start over
        resetn_in = 1'b0;
        repeat (2) @(posedge clk_in);
        #1 resetn_in = 1'b1;
        `CHK(irq7_out, 1'b0)
        `CHK(pass_through_select_out, 1'b0)
        chk_rd(10'h206, 8'h00);
        chk_rd(10'h331, 8'h00);
        chk_rd(10'h335, 8'h20);
        stop_test;
    end
endmodule
`default_nettype wire

// ===== test/midi_stick_checker.sv
// port-level checker of the midi and stick readout block
`timescale 1ns/10ps
`default_nettype none
module midi_stick_checker (
    // clock, reset and host port
    input wire logic clk_in, resetn_in, io_rd_in, io_wr_in,
    input wire logic [9:0] io_addr_in,
    input wire logic [7:0] io_wdata_in, io_rdata_out, tx_byte_out,
    // serial, stick and interrupt side
    input wire logic tx_load_out, tx_busy_in, irq7_out,
    input wire logic pass_through_select_out, stick_timing_auto_select_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    // host read or write at one port
    sequence rd_at(a); io_rd_in && io_addr_in == a; endsequence
    sequence wr_at(a); io_wr_in && io_addr_in == a; endsequence
    // an idle transmitter loads the written byte within two cycles
    property tx_send_p;
        logic [7:0] d;
        (wr_at(10'h330) ##0 (!tx_busy_in && !tx_load_out, d = io_wdata_in))
            |-> ##[1:2] (tx_load_out && tx_byte_out == d);
    endproperty
    rst_values_a: assert property ($past(!resetn_in) |-> !irq7_out && io_rdata_out == 8'h00)
        else $error("outputs not idle after reset");
    rdata_hold_a: assert property (!io_rd_in |=> $stable(io_rdata_out))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (rd_at(10'h000) |=> io_rdata_out == 8'h00)
        else $error("unmapped port not zero");
    istat_resv_a: assert property (rd_at(10'h332) |=> io_rdata_out[7:1] == 7'h00)
        else $error("status reserved bits set");
    lstat_resv_a: assert property (rd_at(10'h335) |=> (io_rdata_out & 8'hD4) == 8'h00)
        else $error("line status reserved bits set");
    irq_status_a: assert property (rd_at(10'h332) ##0 irq7_out |=> io_rdata_out[0])
        else $error("line seven high without pending");
    thru_reg_a: assert property (wr_at(10'h331) |=>
        pass_through_select_out == $past(io_wdata_in[4]))
        else $error("pass-through not written");
    auto_reg_a: assert property (wr_at(10'h202) |=>
        stick_timing_auto_select_out == $past(io_wdata_in[6]))
        else $error("stick mode not written");
    irq_gate_a: assert property (wr_at(10'h202) ##0 !io_wdata_in[0] |=> !irq7_out)
        else $error("line seven high with master enable off");
    tx_send_a: assert property (tx_send_p)
        else $error("written byte not loaded");
endmodule
bind midi_stick_readout midi_stick_checker i_midi_stick_checker (.*);
`default_nettype wire
